//--- hw/pmt_divider.v
// programmable modulo counter used for both the input and output dividers
`timescale 1ns/1ns
module pmt_divider #(
   parameter WIDTH = 4
) (
   // clock and control
   input  wire             clk_i,
   input  wire             rst_i,
   input  wire             ce_i,
   input  wire             clr_i,
   // count event and terminal value
   input  wire             tick_i,
   input  wire [WIDTH-1:0] last_i,
   // one pulse per completed ratio
   output wire             done_o
);

   reg [WIDTH-1:0] cnt_ff;

   // done is combinational so the caller sees it in the tick cycle
   assign done_o = tick_i && (cnt_ff >= last_i);

   // counter restarts on clear or on completion
   always @(posedge clk_i)
   begin
      if (rst_i)
         cnt_ff <= {WIDTH{1'b0}};
      else if (ce_i)
      begin
         if (clr_i)
            cnt_ff <= {WIDTH{1'b0}};
         else if (done_o)
            cnt_ff <= {WIDTH{1'b0}};
         else if (tick_i)
            cnt_ff <= cnt_ff + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end

endmodule // pmt_divider

//--- hw/pmt_timer.v
// eight-bit period match timer with dividers, apb registers and interrupt
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ns
`include "pmt_defines.vh"
// register map, byte address is four times the index:
//   count   index 11, read/write, clears on reset
//   control index 12, bit 7 reads zero, run in bit 2
//   period  index 92, all ones after reset
//   flag    index 0C, bit 1 set by the output divider, write one clears
//   mask    index 8C, bit 1 lets the flag raise the interrupt
// a bus access takes one wait state: ready rises one edge after the
// access phase opens and stands for one cycle
// the interrupt output is high while flag and mask share a set bit

module pmt_timer (
   // clock, reset, enable
   input  wire        CLK_I,
   input  wire        SYS_RST_I,
   input  wire        CE_I,
   // apb slave
   input  wire        PSEL_I,
   input  wire        PENABLE_I,
   input  wire        PWRITE_I,
   input  wire [11:0] PADDR_I,
   input  wire [31:0] PWDATA_I,
   input  wire [3:0]  PSTRB_I,
   output reg  [31:0] PRDATA_O,
   output reg         PREADY_O,
   output reg         PSLVERR_O,
   // interrupt
   output reg         IRQ_O,
   // time base to the serial port and the capture/compare unit
   output reg         SER_MATCH_O,
   output reg         CAP_MATCH_O,
   output reg  [7:0]  CAP_COUNT_O
);

   // registers and their next values
   reg  [7:0] count_ff;
   reg  [7:0] period_ff;
   reg  [6:0] control_ff;
   reg  [7:0] flag_ff;
   reg  [7:0] mask_ff;
   reg  [1:0] instr_ff;
   reg  [7:0] nxt_count;
   reg  [7:0] nxt_flag;
   reg  [31:0] nxt_rdata;
   reg        nxt_err;

   // decode and strobe nets
   wire       instr_tick;
   wire       inc_tick;
   wire       post_done;
   wire       match;
   wire       clr_div;
   wire       acc;
   wire       wr;
   wire       sel_count;
   wire       sel_control;
   wire       sel_period;
   wire       sel_flag;
   wire       sel_mask;
   wire       hit;
   wire [3:0] pre_last;
   // per-register write strobes
   wire       wr_count;
   wire       wr_control;
   wire       wr_period;
   wire       wr_flag;
   wire       wr_mask;

   // only the match bit of the flag and mask words is built
   localparam [7:0] FLAG_IMPL = 8'h01 << `PMT_FLAG_MATCH;

   // maps register index to the apb byte address and compares
   function addr_is;
      input [11:0] addr;
      input [7:0]  idx;
      begin
         addr_is = (addr == {2'b00, idx, 2'b00});
      end
   endfunction

   // input divider terminal value from the select field
   function [3:0] pre_terminal;
      input [1:0] sel;
      begin
         case (sel)
            2'b00:   pre_terminal = 4'h0;
            2'b01:   pre_terminal = 4'h3;
            default: pre_terminal = 4'hF;
         endcase
      end
   endfunction

   // apb decode; access phase with one wait state, writes take effect at the edge that ends its ready cycle
   assign acc         = PSEL_I && PENABLE_I && PREADY_O;
   assign wr          = acc && PWRITE_I && PSTRB_I[0];
   assign sel_count   = addr_is(PADDR_I, `PMT_IDX_COUNT);
   assign sel_control = addr_is(PADDR_I, `PMT_IDX_CONTROL);
   assign sel_period  = addr_is(PADDR_I, `PMT_IDX_PERIOD);
   assign sel_flag    = addr_is(PADDR_I, `PMT_IDX_FLAG);
   assign sel_mask    = addr_is(PADDR_I, `PMT_IDX_MASK);
   assign hit = sel_count | sel_control | sel_period | sel_flag | sel_mask;

   // one write strobe per register; a write to an unmapped word is dropped
   assign wr_count   = wr && sel_count;
   assign wr_control = wr && sel_control;
   assign wr_period  = wr && sel_period;
   assign wr_flag    = wr && sel_flag;
   assign wr_mask    = wr && sel_mask;

   // divider counters restart on count or control writes; the quarter
   // phase counter does not, so a write never shortens the next tick
   assign clr_div = wr_count || wr_control;

   // instruction clock tick, gated by run so the divider chain sleeps
   assign instr_tick = control_ff[`PMT_CTL_RUN] && (instr_ff == 2'b11);
   assign pre_last   = pre_terminal(control_ff[`PMT_CTL_IN_HI:`PMT_CTL_IN_LO]);
   assign match      = inc_tick && (count_ff == period_ff);

   // input divider: 1, 4 or 16 instruction clocks per increment
   pmt_divider #(
      .WIDTH (4)
   ) u_pre (
      .clk_i  (CLK_I),
      .rst_i  (SYS_RST_I),
      .ce_i   (CE_I),
      .clr_i  (clr_div),
      .tick_i (instr_tick),
      .last_i (pre_last),
      .done_o (inc_tick)
   );

   // output divider: field plus one matches per flag
   pmt_divider #(
      .WIDTH (4)
   ) u_post (
      .clk_i  (CLK_I),
      .rst_i  (SYS_RST_I),
      .ce_i   (CE_I),
      .clr_i  (clr_div),
      .tick_i (match),
      .last_i (control_ff[`PMT_CTL_OUT_MSB:`PMT_CTL_OUT_LSB]),
      .done_o (post_done)
   );

   // quarter divider for the instruction clock; free so phase is steady,
   // at the cost of up to three clocks of jitter on the first tick after run
   always @(posedge CLK_I)
   begin
      if (SYS_RST_I)
         instr_ff <= 2'b00;
      else if (CE_I)
         instr_ff <= instr_ff + 2'b01;
   end

   // next count: software write wins over the increment; a period below the
   // current count lets the count run on through ff and wrap to zero
   always @*
   begin
      nxt_count = count_ff;
      if (wr_count)
         nxt_count = PWDATA_I[7:0];
      else if (match)
         nxt_count = 8'h00;
      else if (inc_tick)
         nxt_count = count_ff + 8'h01;
   end

   // sticky flags: hardware set wins over write-one-to-clear, so an event
   // landing on the clear cycle is never lost
   always @*
   begin
      nxt_flag = flag_ff;
      if (wr_flag)
         nxt_flag = flag_ff & ~PWDATA_I[7:0];
      if (post_done)
         nxt_flag[`PMT_FLAG_MATCH] = 1'b1;
      nxt_flag = nxt_flag & FLAG_IMPL;
   end

   // read mux; unmapped addresses answer with an error and zero data;
   // a count read shows the value after this edge's update
   always @*
   begin
      nxt_rdata = 32'h00000000;
      nxt_err   = !hit;
      if (sel_count)
         nxt_rdata[7:0] = nxt_count;
      else if (sel_control)
         nxt_rdata[7:0] = {1'b0, control_ff};
      else if (sel_period)
         nxt_rdata[7:0] = period_ff;
      else if (sel_flag)
         nxt_rdata[7:0] = flag_ff;
      else if (sel_mask)
         nxt_rdata[7:0] = mask_ff;
   end

   // count and flags; a control write leaves the count alone, and reset
   // clears every counter of the chain
   always @(posedge CLK_I)
   begin
      if (SYS_RST_I)
      begin
         count_ff <= `PMT_RST_COUNT;
         flag_ff  <= 8'h00;
      end
      else if (CE_I)
      begin
         count_ff <= nxt_count;
         flag_ff  <= nxt_flag;
      end
   end

   // period register, all ones after reset
   always @(posedge CLK_I)
   begin
      if (SYS_RST_I)
         period_ff <= `PMT_RST_PERIOD;
      else if (CE_I && wr_period)
         period_ff <= PWDATA_I[7:0];
   end

   // control register; bit 7 is not stored at all
   always @(posedge CLK_I)
   begin
      if (SYS_RST_I)
         control_ff <= `PMT_RST_CONTROL;
      else if (CE_I && wr_control)
         control_ff <= PWDATA_I[6:0];
   end

   // interrupt mask, only the match bit can be set
   always @(posedge CLK_I)
   begin
      if (SYS_RST_I)
         mask_ff <= 8'h00;
      else if (CE_I && wr_mask)
         mask_ff <= PWDATA_I[7:0] & FLAG_IMPL;
   end

   // apb answer: ready one edge after the access phase opens, data registered;
   // ready falls right after, so a held request is answered again every second cycle
   always @(posedge CLK_I)
   begin
      if (SYS_RST_I)
      begin
         PREADY_O  <= 1'b0;
         PRDATA_O  <= 32'h00000000;
         PSLVERR_O <= 1'b0;
      end
      else if (CE_I)
      begin
         PREADY_O  <= PSEL_I && PENABLE_I && !PREADY_O;
         PSLVERR_O <= PSEL_I && PENABLE_I && !PREADY_O && nxt_err;
         if (PSEL_I && PENABLE_I && !PREADY_O && !PWRITE_I)
            PRDATA_O <= nxt_rdata;
         else
            PRDATA_O <= 32'h00000000;
      end
   end

   // interrupt level; uses the next flag so it follows the set in one edge
   always @(posedge CLK_I)
   begin
      if (SYS_RST_I)
         IRQ_O <= 1'b0;
      else if (CE_I)
         IRQ_O <= |(nxt_flag & mask_ff);
   end

   // time base to the serial port and capture/compare unit, all registered
   always @(posedge CLK_I)
   begin
      if (SYS_RST_I)
      begin
         SER_MATCH_O <= 1'b0;
         CAP_MATCH_O <= 1'b0;
         CAP_COUNT_O <= 8'h00;
      end
      else if (CE_I)
      begin
         SER_MATCH_O <= match;
         CAP_MATCH_O <= match;
         CAP_COUNT_O <= nxt_count;
      end
   end

endmodule // pmt_timer

//--- shared/pmt_defines.vh
// constants for the period match timer: offsets, fields, resets, timing
`ifndef PMT_DEFINES_VH
`define PMT_DEFINES_VH

// register indices as printed; byte address is four times the index
`define PMT_IDX_COUNT       8'h11
`define PMT_IDX_CONTROL     8'h12
`define PMT_IDX_PERIOD      8'h92
`define PMT_IDX_FLAG        8'h0C
`define PMT_IDX_MASK        8'h8C
`define PMT_ADDR_W          10

// control register fields
`define PMT_CTL_IN_LO       0
`define PMT_CTL_IN_HI       1
`define PMT_CTL_RUN         2
`define PMT_CTL_OUT_LSB     3
`define PMT_CTL_OUT_MSB     6

// flag register bit of the match event
`define PMT_FLAG_MATCH      1

// reset values
`define PMT_RST_COUNT       8'h00
`define PMT_RST_CONTROL     7'h00
`define PMT_RST_PERIOD      8'hFF

// instruction clock is the input clock divided by four
`define PMT_INSTR_DIV       4
`define PMT_INSTR_DIV_W     2

`endif

//--- tb/pmt_checker.sv
// assertion checker on the timer's outside ports
`timescale 1ns/1ns
module pmt_checker (
   // clock, reset, enable
   input logic        CLK_I,
   input logic        SYS_RST_I,
   input logic        CE_I,
   // apb side
   input logic        PSEL_I,
   input logic        PENABLE_I,
   input logic        PWRITE_I,
   input logic [11:0] PADDR_I,
   input logic [31:0] PWDATA_I,
   input logic [3:0]  PSTRB_I,
   input logic [31:0] PRDATA_O,
   input logic        PREADY_O,
   input logic        PSLVERR_O,
   // interrupt and time base
   input logic        IRQ_O,
   input logic        SER_MATCH_O,
   input logic        CAP_MATCH_O,
   input logic [7:0]  CAP_COUNT_O
);
   // five words decode; a count write is the only legal jump of the count
   wire map = PADDR_I inside {12'h044, 12'h048, 12'h248, 12'h030, 12'h230};
   wire cwr = CE_I && PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PSTRB_I[0] &&
      PADDR_I == 12'h044;
   default clocking @(posedge CLK_I); endclocking
   default disable iff (SYS_RST_I);
   a_ready_wait: assert property (CE_I && PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O)
      else $error("ready missing");
   a_ready_pulse: assert property (CE_I && PREADY_O |=> !PREADY_O)
      else $error("ready too long");
   a_err_map: assert property (PREADY_O |-> PSLVERR_O == !map) else $error("bad slverr");
   a_ctl_msb: assert property (PREADY_O && !PWRITE_I && PADDR_I == 12'h048 |->
      PRDATA_O[31:7] == 25'h0) else $error("control bit 7 set");
   a_rst_clear: assert property ($fell(SYS_RST_I) |-> !IRQ_O && CAP_COUNT_O == 8'h00)
      else $error("not cleared");
   a_match_same: assert property (SER_MATCH_O == CAP_MATCH_O)
      else $error("match outputs differ");
   a_match_wrap: assert property (SER_MATCH_O && !$past(cwr) |-> CAP_COUNT_O == 8'h00)
      else $error("match without wrap");
   a_count_step: assert property (!$past(cwr) && $changed(CAP_COUNT_O) |->
      CAP_COUNT_O == 8'($past(CAP_COUNT_O) + 8'h01) || CAP_COUNT_O == 8'h00)
      else $error("count jumped");
endmodule // pmt_checker
bind pmt_timer pmt_checker i_chk (.CLK_I, .SYS_RST_I, .CE_I, .PSEL_I, .PENABLE_I, .PWRITE_I,
   .PADDR_I, .PWDATA_I, .PSTRB_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .IRQ_O, .SER_MATCH_O,
   .CAP_MATCH_O, .CAP_COUNT_O);

//--- tb/tb_top.sv
// self-checking bench for the period match timer
`timescale 1ns/1ns
module tb_top;
   logic        clk = 1'b0, rst = 1'b1, sel = 1'b0, en = 1'b0, wr = 1'b0;
   logic [11:0] adr = 12'h000;
   logic [31:0] wd = 32'h0, prd, rd;
   logic        rdy, err, irq, smatch, cmatch;
   logic [7:0]  cnt, per, v;
   int          error_cnt = 0, compares = 0, seed = 32'hB0C56EDF, ps, div, np, nc, tl;
   always #4 clk = ~clk;
   pmt_timer i_dut (.CLK_I(clk), .SYS_RST_I(rst), .CE_I(1'b1), .PSEL_I(sel), .PENABLE_I(en),
      .PWRITE_I(wr), .PADDR_I(adr), .PWDATA_I(wd), .PSTRB_I(4'hF), .PRDATA_O(prd),
      .PREADY_O(rdy), .PSLVERR_O(err), .IRQ_O(irq), .SER_MATCH_O(smatch),
      .CAP_MATCH_O(cmatch), .CAP_COUNT_O(cnt));
   // one comparison against the model's figure
   task automatic chk(input string s, input logic [31:0] seen, exp);
      compares++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", s, exp, seen);
      end
   endtask
   // apb transfer; no wait count assumed, only a bound on the wait
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic e = 1'b0);
      @(posedge clk);
      sel <= 1'b1;
      wr <= w;
      adr <= a;
      wd <= d;
      @(posedge clk);
      en <= 1'b1;
      for (int n = 0; n < 40 && rdy !== 1'b1; n++)
         @(posedge clk);
      rd = prd;
      chk("ready and slverr", {rdy, err}, {1'b1, e});
      sel <= 1'b0;
      en <= 1'b0;
   endtask
   task automatic summarize;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // four sweeps of at most about 8200 cycles each end far below this span
   initial
   begin
      #600000;
      error_cnt++;
      summarize();
   end
   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      // reset values, unimplemented control bit, unmapped word
      apb(0, 12'h044, 0);
      chk("count", rd, 32'h0);
      apb(0, 12'h248, 0);
      chk("period", rd, 32'hFF);
      apb(1, 12'h048, 32'hF8);
      apb(0, 12'h048, 0);
      chk("control", rd, 32'h78);
      apb(0, 12'h100, 0, 1);
      chk("unmapped", rd, 32'h0);
      // one sweep per input divider select, random period and ratio
      for (int s = 0; s < 4; s++)
      begin
         per = 8'($random(seed)) & 8'h07;
         ps = $random(seed) & 15;
         div = s == 0 ? 1 : s == 1 ? 4 : 16;
         v = 8'($random(seed));
         apb(1, 12'h044, {24'h0, v});
         apb(0, 12'h044, 0);
         chk("count", rd, {24'h0, v});
         apb(1, 12'h044, 0);
         apb(1, 12'h248, {24'h0, per});
         apb(1, 12'h230, 32'h2);
         apb(1, 12'h048, 32'(ps * 8 + 4 + s));
         np = 0;
         nc = 0;
         for (int n = 0; n < 20000 && irq !== 1'b1; n++)
         begin
            @(posedge clk);
            if (cmatch === 1'b1)
               nc++;
            if (smatch === 1'b1)
            begin
               if (np > 0)
                  chk("match gap", n - tl, 4 * div * (per + 1));
               np++;
               tl = n;
            end
         end
         chk("matches per flag", np, ps + 1);
         chk("compare unit matches", nc, ps + 1);
         // stopped count must hold across a control write
         apb(1, 12'h048, 0);
         apb(0, 12'h044, 0);
         v = rd[7:0];
         apb(1, 12'h048, 32'h7B);
         repeat (64) @(posedge clk);
         apb(0, 12'h044, 0);
         chk("held count", rd, {24'h0, v});
         chk("time base count", cnt, {24'h0, v});
         apb(1, 12'h230, 0);
         apb(0, 12'h030, 0);
         chk("flag", rd, 32'h2);
         chk("masked irq", irq, 1'b0);
         apb(1, 12'h030, 32'h2);
         apb(0, 12'h030, 0);
         chk("cleared flag", rd, 32'h0);
      end
      summarize();
   end
endmodule // tb_top
